/* rtl/timer_pin_pkg.sv */
// Summary of operation
// RULE1 - pin bits: b at 16, a at 17, clock at 18
// RULE2 - 0x00 hands pin to gpio, 0x04 returns it
// RULE3 - owner status at 0x08, resets all gpio
// RULE4 - 0x10 output, 0x14 input, status 0x18
// RULE5 - set/clear output data, status at 0x38
// RULE6 - 0x3C reads pin levels registered each clock
// RULE7 - open drain on/off, status at 0x48
// RULE8 - clock gate on/off, power status 0x58
// RULE9 - timer command, config, interrupt mask registers
// RULE10 - counter value and compare registers a b c
// RULE11 - group command 0x300, group config 0x304
// RULE12 - output data bit sets driven level
// RULE13 - open drain pin only pulls low
// RULE14 - zero writes no effect; reserved reads zero
package timer_pin_pkg;
    localparam logic [11:0] OFS_GPIO_EN    = 12'h000;
    localparam logic [11:0] OFS_GPIO_DIS   = 12'h004;
    localparam logic [11:0] OFS_OWNER      = 12'h008;
    localparam logic [11:0] OFS_OUT_EN     = 12'h010;
    localparam logic [11:0] OFS_OUT_DIS    = 12'h014;
    localparam logic [11:0] OFS_DIR        = 12'h018;
    localparam logic [11:0] OFS_SET        = 12'h030;
    localparam logic [11:0] OFS_CLR        = 12'h034;
    localparam logic [11:0] OFS_ODATA      = 12'h038;
    localparam logic [11:0] OFS_LEVEL      = 12'h03c;
    localparam logic [11:0] OFS_OD_EN      = 12'h040;
    localparam logic [11:0] OFS_OD_DIS     = 12'h044;
    localparam logic [11:0] OFS_OD         = 12'h048;
    localparam logic [11:0] OFS_CLK_ON     = 12'h050;
    localparam logic [11:0] OFS_CLK_OFF    = 12'h054;
    localparam logic [11:0] OFS_PWR        = 12'h058;
    localparam logic [11:0] OFS_TCMD       = 12'h060;
    localparam logic [11:0] OFS_TCFG       = 12'h064;
    localparam logic [11:0] OFS_TFLAGS     = 12'h070;
    localparam logic [11:0] OFS_IRQ_EN     = 12'h074;
    localparam logic [11:0] OFS_IRQ_DIS    = 12'h078;
    localparam logic [11:0] OFS_IRQ_MASK   = 12'h07c;
    localparam logic [11:0] OFS_COUNT      = 12'h080;
    localparam logic [11:0] OFS_CMP_A      = 12'h084;
    localparam logic [11:0] OFS_CMP_B      = 12'h088;
    localparam logic [11:0] OFS_CMP_C      = 12'h08c;
    localparam logic [11:0] OFS_GRP_CMD    = 12'h300;
    localparam logic [11:0] OFS_GRP_CFG    = 12'h304;

    localparam int          PIN_LSB        = 16;
    localparam int          NUM_PINS       = 3;
    localparam logic [2:0]  OWNER_RST      = 3'h7;
    localparam logic [2:0]  PINS_ZERO      = 3'h0;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

    typedef struct packed {
        logic [2:0] owner;
        logic [2:0] dir;
        logic [2:0] odata;
        logic [2:0] od;
    } pin_cfg_s;

    typedef struct packed {
        logic [2:0] o;
        logic [2:0] oe;
    } pin_drive_s;
endpackage : timer_pin_pkg

/* rtl/timer_channel_pin_io_regs.sv */
`timescale 1ns/100ps
module timer_channel_pin_io_regs
    import timer_pin_pkg::*;
(
    input  wire logic        hclk,          // core clock
    input  wire logic        hresetn,       // async reset, active low
    input  wire logic        hsel,          // slave select
    input  wire logic [31:0] haddr,         // byte address
    input  wire logic [1:0]  htrans,        // transfer type
    input  wire logic        hwrite,        // write when high
    input  wire logic [2:0]  hsize,         // transfer size
    input  wire logic        hready,        // bus ready in
    input  wire logic [31:0] hwdata,        // write data
    output logic      [31:0] hrdata,        // read data
    output logic             hreadyout,     // slave ready
    output logic             hresp,         // always okay
    input  wire logic [2:0]  timer_pin_o,   // timer drive level {clk,a,b}
    input  wire logic [2:0]  timer_pin_oe,  // timer drive enable
    input  wire logic [15:0] timer_count,   // counter value from core
    input  wire logic [31:0] timer_status,  // status from core
    input  wire logic [2:0]  pin_i,         // pin levels {clk,a,b}
    output logic      [2:0]  pin_o,         // pin output level
    output logic      [2:0]  pin_oe,        // pin output enable
    output logic      [2:0]  gpio_owner,    // pins owned by gpio
    output logic             chan_clk_en,   // channel clock gate
    output logic      [31:0] tcmd_data,     // timer command value
    output logic             tcmd_strobe,   // timer command pulse
    output logic      [31:0] gcmd_data,     // group command value
    output logic             gcmd_strobe    // group command pulse
);

////////////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] pins(input logic [31:0] w);
        pins = w[PIN_LSB +: NUM_PINS]; // [RULE1]
    endfunction : pins

    logic        wr_pend_ff;
    logic [11:0] wr_addr_ff;
    pin_cfg_s    cfg_ff;
    logic [2:0]  level_ff;
    logic [31:0] pwr_ff;
    logic [31:0] tcfg_ff;
    logic [31:0] irq_mask_ff;
    logic [31:0] cmp_a_ff;
    logic [31:0] cmp_b_ff;
    logic [31:0] cmp_c_ff;
    logic [31:0] gcfg_ff;
    logic [2:0]  wp;
    logic        rd_req;
    logic [31:0] nxt_rdata;

    assign wp     = pins(hwdata);
    assign rd_req = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;

////////////////////////////////////////////////////////////////////////////////
    // address phase capture; writes take effect in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
        end else if (hready) begin
            wr_pend_ff <= hsel && htrans == HTRANS_NONSEQ && hwrite;
            wr_addr_ff <= haddr[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff.owner <= OWNER_RST; // [RULE3]
            cfg_ff.dir   <= PINS_ZERO; // [RULE4]
            cfg_ff.odata <= PINS_ZERO; // [RULE5]
            cfg_ff.od    <= PINS_ZERO; // [RULE7]
        end else if (wr_pend_ff) begin
            case (wr_addr_ff)
                OFS_GPIO_EN:  cfg_ff.owner <= cfg_ff.owner | wp;  // [RULE2] [RULE14]
                OFS_GPIO_DIS: cfg_ff.owner <= cfg_ff.owner & ~wp; // [RULE2] [RULE14]
                OFS_OUT_EN:   cfg_ff.dir   <= cfg_ff.dir | wp;    // [RULE4]
                OFS_OUT_DIS:  cfg_ff.dir   <= cfg_ff.dir & ~wp;   // [RULE4]
                OFS_SET:      cfg_ff.odata <= cfg_ff.odata | wp;  // [RULE5]
                OFS_CLR:      cfg_ff.odata <= cfg_ff.odata & ~wp; // [RULE5]
                OFS_OD_EN:    cfg_ff.od    <= cfg_ff.od | wp;     // [RULE7]
                OFS_OD_DIS:   cfg_ff.od    <= cfg_ff.od & ~wp;    // [RULE7]
                default:      cfg_ff       <= cfg_ff;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_ff <= WORD_ZERO;
        end else if (wr_pend_ff && wr_addr_ff == OFS_CLK_ON) begin
            pwr_ff <= pwr_ff | hwdata; // [RULE8]
        end else if (wr_pend_ff && wr_addr_ff == OFS_CLK_OFF) begin
            pwr_ff <= pwr_ff & ~hwdata; // [RULE8]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_ff <= WORD_ZERO;
        end else if (wr_pend_ff && wr_addr_ff == OFS_IRQ_EN) begin
            irq_mask_ff <= irq_mask_ff | hwdata; // [RULE9] [RULE14]
        end else if (wr_pend_ff && wr_addr_ff == OFS_IRQ_DIS) begin
            irq_mask_ff <= irq_mask_ff & ~hwdata; // [RULE9]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tcfg_ff  <= WORD_ZERO;
            cmp_a_ff <= WORD_ZERO;
            cmp_b_ff <= WORD_ZERO;
            cmp_c_ff <= WORD_ZERO;
            gcfg_ff  <= WORD_ZERO;
        end else if (wr_pend_ff) begin
            case (wr_addr_ff)
                OFS_TCFG:    tcfg_ff  <= hwdata; // [RULE9]
                OFS_CMP_A:   cmp_a_ff <= hwdata; // [RULE10]
                OFS_CMP_B:   cmp_b_ff <= hwdata; // [RULE10]
                OFS_CMP_C:   cmp_c_ff <= hwdata; // [RULE10]
                OFS_GRP_CFG: gcfg_ff  <= hwdata; // [RULE11]
                default:     gcfg_ff  <= gcfg_ff;
            endcase
        end
    end

    // command strobes are one-cycle pulses in the data phase's following cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tcmd_strobe <= 1'b0;
            tcmd_data   <= WORD_ZERO;
            gcmd_strobe <= 1'b0;
            gcmd_data   <= WORD_ZERO;
        end else begin
            tcmd_strobe <= wr_pend_ff && wr_addr_ff == OFS_TCMD; // [RULE9]
            gcmd_strobe <= wr_pend_ff && wr_addr_ff == OFS_GRP_CMD; // [RULE11]
            if (wr_pend_ff && wr_addr_ff == OFS_TCMD) begin
                tcmd_data <= hwdata;
            end
            if (wr_pend_ff && wr_addr_ff == OFS_GRP_CMD) begin
                gcmd_data <= hwdata;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // pin mux: gpio or timer owns each pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_o  <= PINS_ZERO;
            pin_oe <= PINS_ZERO;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (cfg_ff.owner[i]) begin
                    // open drain drives low only [RULE13]
                    pin_o[i]  <= cfg_ff.odata[i] && !cfg_ff.od[i]; // [RULE12]
                    pin_oe[i] <= cfg_ff.dir[i] && (!cfg_ff.od[i] || !cfg_ff.odata[i]);
                end else begin
                    pin_o[i]  <= timer_pin_o[i] && !cfg_ff.od[i];
                    pin_oe[i] <= timer_pin_oe[i] && (!cfg_ff.od[i] || !timer_pin_o[i]);
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_ff    <= PINS_ZERO;
            gpio_owner  <= OWNER_RST;
            chan_clk_en <= 1'b0;
        end else begin
            level_ff    <= pin_i; // [RULE6]
            gpio_owner  <= cfg_ff.owner;
            chan_clk_en <= pwr_ff[0];
        end
    end

////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_rdata = WORD_ZERO;
        case (haddr[11:0])
            OFS_OWNER:    nxt_rdata[PIN_LSB +: NUM_PINS] = cfg_ff.owner; // [RULE3]
            OFS_DIR:      nxt_rdata[PIN_LSB +: NUM_PINS] = cfg_ff.dir;   // [RULE4]
            OFS_ODATA:    nxt_rdata[PIN_LSB +: NUM_PINS] = cfg_ff.odata; // [RULE5]
            OFS_LEVEL:    nxt_rdata[PIN_LSB +: NUM_PINS] = level_ff;     // [RULE6]
            OFS_OD:       nxt_rdata[PIN_LSB +: NUM_PINS] = cfg_ff.od;    // [RULE7]
            OFS_PWR:      nxt_rdata = pwr_ff;       // [RULE8]
            OFS_TCFG:     nxt_rdata = tcfg_ff;      // [RULE9]
            OFS_TFLAGS:   nxt_rdata = timer_status;
            OFS_IRQ_MASK: nxt_rdata = irq_mask_ff;  // [RULE9]
            OFS_COUNT:    nxt_rdata[15:0] = timer_count; // [RULE10]
            OFS_CMP_A:    nxt_rdata = cmp_a_ff;     // [RULE10]
            OFS_CMP_B:    nxt_rdata = cmp_b_ff;
            OFS_CMP_C:    nxt_rdata = cmp_c_ff;
            OFS_GRP_CFG:  nxt_rdata = gcfg_ff;      // [RULE11]
            default:      nxt_rdata = WORD_ZERO;    // [RULE14]
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= WORD_ZERO;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_req) begin
                hrdata <= nxt_rdata;
            end
        end
    end

    logic unused_ok;
    assign unused_ok = ^{haddr[31:12], hsize};
endmodule : timer_channel_pin_io_regs

/* testbench/timer_channel_pin_io_regs_checker.sv */
`timescale 1ns/100ps
module timer_channel_pin_io_regs_checker
    import timer_pin_pkg::*;
(
    input wire logic        hclk,        // clock
    input wire logic        hresetn,     // reset, active low
    input wire logic        hsel,        // select
    input wire logic [31:0] haddr,       // address
    input wire logic [1:0]  htrans,      // transfer type
    input wire logic        hwrite,      // write
    input wire logic        hready,      // bus ready
    input wire logic [31:0] hwdata,      // write data
    input wire logic        hreadyout,   // slave ready
    input wire logic        hresp,       // response
    input wire logic [2:0]  gpio_owner,  // owner copy
    input wire logic        chan_clk_en, // clock gate
    input wire logic [31:0] tcmd_data,   // command value
    input wire logic        tcmd_strobe, // command pulse
    input wire logic        gcmd_strobe  // group pulse
);
logic        wr_ff;
logic [11:0] adr_ff;
// data phase of an accepted write
always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wr_ff <= 1'b0;
    else wr_ff <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) adr_ff <= 12'h000;
    else adr_ff <= haddr[11:0];
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
a_no_wait: assert property (hreadyout) else $error("wait state seen");
a_resp_okay: assert property (!hresp) else $error("error response seen");
a_tcmd_pulse: assert property (wr_ff && adr_ff == OFS_TCMD |=> tcmd_strobe ##1 !tcmd_strobe)
    else $error("command pulse wrong");
a_tcmd_data: assert property (wr_ff && adr_ff == OFS_TCMD |=> tcmd_data == $past(hwdata))
    else $error("command value wrong");
a_gcmd_pulse: assert property (wr_ff && adr_ff == OFS_GRP_CMD |=> gcmd_strobe)
    else $error("group pulse missing");
a_owner_set: assert property (wr_ff && adr_ff == OFS_GPIO_EN && hwdata[16] |-> ##[1:2] gpio_owner[0])
    else $error("pin not handed over");
a_owner_clr: assert property (wr_ff && adr_ff == OFS_GPIO_DIS && hwdata[17] |-> ##[1:2] !gpio_owner[1])
    else $error("pin not returned");
a_clk_on: assert property (wr_ff && adr_ff == OFS_CLK_ON && hwdata[0] |-> ##[1:2] chan_clk_en)
    else $error("clock not enabled");
c_tcmd: cover property (tcmd_strobe);
c_gcmd: cover property (gcmd_strobe);
c_clk: cover property ($fell(chan_clk_en));
endmodule : timer_channel_pin_io_regs_checker
bind timer_channel_pin_io_regs timer_channel_pin_io_regs_checker timer_channel_pin_io_regs_checker_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp,
    .gpio_owner, .chan_clk_en, .tcmd_data, .tcmd_strobe, .gcmd_strobe);

/* testbench/timer_channel_pin_io_regs_tb_top.sv */
`timescale 1ns/100ps
module timer_channel_pin_io_regs_tb_top import timer_pin_pkg::*;;
logic        hclk, hresetn, hwrite, hreadyout, hresp, tcmd_strobe, gcmd_strobe, chan_clk_en, hsel;
logic [31:0] haddr, hwdata, hrdata, tcmd_data, gcmd_data, timer_status, seed, rdv, d, d2;
logic [1:0]  htrans;
logic [2:0]  tpo, tpoe, pin_i, pin_o, pin_oe, gpio_owner, own, dir, odv, od, m;
logic [5:0]  e6;
logic [15:0] timer_count;
int          fails, compares, op;
logic [11:0] wofs [8] = '{12'h000, 12'h004, 12'h010, 12'h014, 12'h030, 12'h034, 12'h040, 12'h044};
logic [11:0] sofs [4] = '{12'h008, 12'h018, 12'h038, 12'h048};
logic [11:0] rw [5]   = '{12'h064, 12'h084, 12'h088, 12'h08c, 12'h304};
logic [11:0] zofs [18] = '{12'h000, 12'h00c, 12'h018, 12'h01c, 12'h038, 12'h03c, 12'h048, 12'h04c,
    12'h058, 12'h060, 12'h064, 12'h068, 12'h07c, 12'h080, 12'h084, 12'h088, 12'h08c, 12'h304};
timer_channel_pin_io_regs timer_channel_pin_io_regs_i (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .timer_pin_o(tpo), .timer_pin_oe(tpoe), .timer_count, .timer_status, .pin_i, .pin_o,
    .pin_oe, .gpio_owner, .chan_clk_en, .tcmd_data, .tcmd_strobe, .gcmd_data, .gcmd_strobe);
initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
end
////////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
endfunction : xs
function automatic logic [31:0] pw(input logic [2:0] p);
    return {13'h0000, p, 16'h0000};
endfunction : pw
// expected pin drive {o, oe} from the register model and timer drive
function automatic logic [5:0] drv();
    logic [2:0] l, e;
    l = (own & odv) | (~own & tpo);
    e = (own & dir) | (~own & tpoe);
    return {l & ~od, (e & ~od) | (e & ~l & od)};
endfunction : drv
task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask : summarize
task automatic wt();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
        n++;
        @(posedge hclk);
    end
    if (n >= 20) begin
        fails++;
        summarize();
    end
endtask : wt
task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    haddr  <= {20'h0_0000, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wt();
    htrans <= 2'h0;
    hwdata <= wd;
    wt();
    rdv = hrdata;
endtask : xfer
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
        fails++;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
endtask : chk
task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, e, rdv);
endtask : rchk
////////////////////////////////////////////////////////////////////////////////
initial begin
    seed = 32'h0000_4419;
    {fails, compares} = '0;
    {hresetn, haddr, htrans, hwrite, hwdata, tpo, tpoe, timer_count, timer_status, pin_i} = '0;
    {own, dir, odv, od} = {3'h7, 9'h000};
    hsel = 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("owner reset", OFS_OWNER, pw(OWNER_RST));
    foreach (zofs[i]) rchk("zero reset", zofs[i], WORD_ZERO);
    $display("test reset done");
    for (int i = 0; i < 48; i++) begin
        op = (i < 8) ? i : xs() % 8;
        d  = (i < 8) ? 32'h0007_0000 : (i == 8) ? 32'hfff8_ffff : xs();
        d2 = xs();
        case (op)
            0: own = own | d[18:16];
            1: own = own & ~d[18:16];
            2: dir = dir | d[18:16];
            3: dir = dir & ~d[18:16];
            4: odv = odv | d[18:16];
            5: odv = odv & ~d[18:16];
            6: od = od | d[18:16];
            default: od = od & ~d[18:16];
        endcase
        tpo   <= d2[2:0];
        tpoe  <= d2[5:3];
        pin_i <= d2[8:6];
        xfer(1'b1, wofs[op], d);
        repeat (2) @(posedge hclk);
        e6 = drv();
        chk("pin_o", {29'h0, e6[5:3]}, {29'h0, pin_o});
        chk("pin_oe", {29'h0, e6[2:0]}, {29'h0, pin_oe});
        chk("gpio_owner", {29'h0, own}, {29'h0, gpio_owner});
        m = op < 2 ? own : op < 4 ? dir : op < 6 ? odv : od;
        rchk("pin status", sofs[op / 2], pw(m));
        rchk("pin level", OFS_LEVEL, pw(d2[8:6]));
    end
    $display("test pins done");
    foreach (rw[i]) begin
        d = xs();
        xfer(1'b1, rw[i], d);
        rchk("rw reg", rw[i], d);
    end
    // a write while deselected must leave the register alone
    hsel <= 1'b0;
    xfer(1'b1, OFS_GRP_CFG, ~d);
    hsel <= 1'b1;
    rchk("deselected write", OFS_GRP_CFG, d);
    xfer(1'b1, 12'h068, 32'hffff_ffff);
    rchk("reserved", 12'h068, WORD_ZERO);
    d = xs() | 32'h0000_0001;
    xfer(1'b1, OFS_CLK_ON, d);
    rchk("power on", OFS_PWR, d);
    chk("clk_en on", 32'h0000_0001, {31'h0, chan_clk_en});
    xfer(1'b1, OFS_CLK_OFF, 32'h0000_0001);
    rchk("power off", OFS_PWR, d & 32'hffff_fffe);
    chk("clk_en off", WORD_ZERO, {31'h0, chan_clk_en});
    d2 = xs();
    timer_count  <= d2[15:0];
    timer_status <= ~d2;
    rchk("count", OFS_COUNT, {16'h0000, d2[15:0]});
    rchk("flags", OFS_TFLAGS, ~d2);
    for (int j = 0; j < 2; j++) begin
        d = xs();
        xfer(1'b1, j ? OFS_GRP_CMD : OFS_TCMD, d);
        @(posedge hclk);
        chk("cmd strobe", 32'h0000_0001, {31'h0, j ? gcmd_strobe : tcmd_strobe});
        chk("cmd data", d, j ? gcmd_data : tcmd_data);
    end
    $display("test map done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("owner rereset", OFS_OWNER, pw(OWNER_RST));
    rchk("dir rereset", OFS_DIR, WORD_ZERO);
    $display("test second reset done");
    summarize();
end
endmodule : timer_channel_pin_io_regs_tb_top
